/* rtl/udp_pkg.sv */
// package: shared constants and types for the usb endpoint dma slave port
package udp_pkg;

  // ==================================================
  // register map (apb byte offsets)
  localparam logic [7:0] CFG_OFFSET    = 8'h00;
  localparam logic [7:0] COUNT_OFFSET  = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h08;
  localparam logic [7:0] ENDPOINT_DIRECTION_BIT_OFFSET  = 8'h0C;
  localparam logic [7:0] FIFO_OFFSET   = 8'h10;

  // ==================================================
  // configuration register fields
  localparam int CFG_ENABLE_POS   = 0;
  localparam int CFG_ACKONLY_POS  = 1;
  localparam int CFG_BURST_POS    = 2;
  localparam int CFG_COUNT_TERMINATION_ENABLE_POS   = 3;
  localparam int CFG_SHORTP_POS   = 4;
  localparam int CFG_REQPOL_POS   = 5;
  localparam int CFG_ACKPOL_POS   = 6;
  localparam int CFG_EOTPOL_POS   = 7;
  localparam int CFG_INDEX_POS    = 8;
  localparam int CFG_WIDE_POS     = 12;
  localparam logic [31:0] CFG_RESET   = 32'h0000_0000;
  localparam logic [15:0] COUNT_RESET = 16'h0000;

  // ==================================================
  // status register fields
  localparam int STAT_ACTIVE_POS  = 0;
  localparam int STAT_EXTEND_POS  = 1;
  localparam int STAT_CNTEND_POS  = 2;
  localparam int STAT_SHORT_POS   = 3;
  localparam int STAT_SEND_POS    = 4;
  localparam int STAT_DISCARD_POS = 5;

  // ==================================================
  // dma sizes and encodings
  localparam int          NUM_ENDPOINTS = 14;
  localparam int          BURST_BYTES   = 16;
  localparam logic [3:0]  INDEX_FIRST   = 4'h2;

  // ==================================================
  // transfer state machine
  typedef enum logic [1:0] {
    UDP_IDLE   = 2'b00,
    UDP_REQ    = 2'b01,
    UDP_STROBE = 2'b10,
    UDP_WAIT   = 2'b11
  } udp_state_t;

endpackage

/* rtl/udp_fifo_if.sv */
// interface: endpoint fifo access path between the port and its buffer
`timescale 1ns/1ns
interface udp_fifo_if;
  logic [3:0]  epSel;     // endpoint number, 0..13
  logic        rdStb;     // pop one unit
  logic        wrStb;     // push one unit
  logic        wide;      // unit is two bytes
  logic [15:0] wrData;    // data to push
  logic [15:0] rdData;    // data at head
  logic        flush;     // drop buffer content
  logic [10:0] level;     // bytes held

  modport port (output epSel, rdStb, wrStb, wide, wrData, flush, input rdData, level);
  modport buffer (input epSel, rdStb, wrStb, wide, wrData, flush, output rdData, level);
endinterface

/* rtl/udp_ep_buffer.sv */
// endpoint buffers: one byte fifo per endpoint, shared by dma and pio
`timescale 1ns/1ns
module udp_ep_buffer #(
  parameter int DEPTH = 64                 // bytes per endpoint
) (
  input  wire logic clock,                 // system clock
  input  wire logic rst_b,                 // async reset, low
  udp_fifo_if.buffer fifo                  // access path
);
  import udp_pkg::*;
  localparam int AW = $clog2(DEPTH);

  // ==================================================
  // storage, pointers per endpoint
  logic [7:0]  mem [NUM_ENDPOINTS][DEPTH];
  logic [AW:0] wrPtr_reg [NUM_ENDPOINTS];
  logic [AW:0] rdPtr_reg [NUM_ENDPOINTS];
  logic [AW:0] step;
  logic [AW:0] used;
  logic [AW-1:0] rIdx;

  // pointer arithmetic and head read
  always_comb begin
    step = fifo.wide ? (AW+1)'(2) : (AW+1)'(1);
    used = wrPtr_reg[fifo.epSel] - rdPtr_reg[fifo.epSel];
    rIdx = rdPtr_reg[fifo.epSel][AW-1:0];
    fifo.level = 11'(used);
    fifo.rdData = {mem[fifo.epSel][AW'(rIdx + AW'(1))], mem[fifo.epSel][rIdx]};
  end

  // pointers: only the selected endpoint moves, others stay intact
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NUM_ENDPOINTS; i++) begin
        wrPtr_reg[i] <= '0;
        rdPtr_reg[i] <= '0;
      end
    end else if (fifo.flush) begin
      rdPtr_reg[fifo.epSel] <= wrPtr_reg[fifo.epSel];
    end else begin
      if (fifo.wrStb) wrPtr_reg[fifo.epSel] <= wrPtr_reg[fifo.epSel] + step;
      if (fifo.rdStb && used >= step) rdPtr_reg[fifo.epSel] <= rdPtr_reg[fifo.epSel] + step;
    end
  end

  // data array has no reset, so it sits in its own process
  always_ff @(posedge clock) begin
    if (fifo.wrStb && !fifo.flush) begin
      mem[fifo.epSel][wrPtr_reg[fifo.epSel][AW-1:0]] <= fifo.wrData[7:0];
      if (fifo.wide)
        mem[fifo.epSel][AW'(wrPtr_reg[fifo.epSel][AW-1:0] + AW'(1))] <= fifo.wrData[15:8];
    end
  end
endmodule

/* rtl/udp_sync.sv */
// synchroniser: two flops per asynchronous dma control input
`timescale 1ns/1ns
module udp_sync #(
  parameter int WIDTH = 4                  // number of inputs
) (
  input  wire logic             clock,     // system clock
  input  wire logic             rst_b,     // async reset, low
  input  wire logic [WIDTH-1:0] asyncIn,   // raw pins
  output logic      [WIDTH-1:0] syncOut    // synchronised levels
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;

  // first stage feeds only the second
  always_ff @(posedge clock or negedge rst_b) begin
    // every watched pin rests high under the reset polarities, so the flops
    // start at that idle level and no false edge follows reset
    if (!rst_b) begin
      stage1_reg <= '1;
      stage2_reg <= '1;
    end else begin
      stage1_reg <= asyncIn;
      stage2_reg <= stage1_reg;
    end
  end
  assign syncOut = stage2_reg;
endmodule

/* rtl/udp_dma_port.sv */
// top: dma slave port of a usb endpoint controller with apb registers
// How it works
// - ack-only bit clear selects fly-by strobes
// - ack-only bit set selects ack-only mode
// - fourteen endpoints, one dma target at once
// - pio on other endpoints interleaves with dma
// - target index is endpoint plus two
// - direction bit zero reads, one writes
// - acknowledge forces dma endpoint selection
// - single-cycle or burst up to sixteen bytes
// - request, ack, end polarities programmable
// - external end, count, short packet end dma
// - request out, ack and end in
// - fly-by: drive on read, capture write
// - drop request per unit or burst end
// - stop driving bus when ack drops
// - ack-only mode uses ack as strobe
// - external end flushes out, sends in
// - count load on enable, terminate at zero
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ns
module udp_dma_port (
  input  wire logic        clock,          // 25 MHz system clock
  input  wire logic        rst_b,          // async reset, low
  input  wire logic        psel,           // apb select
  input  wire logic        penable,        // apb access phase
  input  wire logic        pwrite,         // apb write
  input  wire logic [7:0]  paddr,          // apb byte address
  input  wire logic [31:0] pwdata,         // apb write data
  output logic      [31:0] prdata,         // apb read data
  output logic             pready,         // apb ready
  output logic             pslverr,        // apb error
  output logic             dmaRequestOut,  // request to controller
  input  wire logic        dmaAcknowledgeIn, // acknowledge from controller
  input  wire logic        transferEndIn,  // end of transfer input
  input  wire logic        readStrobe_b,   // fly-by read strobe, low
  input  wire logic        writeStrobe_b,  // fly-by write strobe, low
  input  wire logic [15:0] dataIn,         // data bus input
  output logic      [15:0] dataOut,        // data bus output
  output logic             dataOe_b,       // data bus enable, low drives
  input  wire logic        shortPacket     // short packet seen by usb side
);
  import udp_pkg::*;

  // ==================================================
  // registers
  logic [31:0] cfg_reg, cfg_next;
  logic [15:0] count_reg, count_next;
  logic [13:0] endpoint_direction_bit_reg, endpoint_direction_bit_next;
  logic [3:0]  pioEp_reg, pioEp_next;
  logic [5:0]  stat_reg, stat_next;
  logic [15:0] remain_reg, remain_next;
  logic [4:0]  burst_reg, burst_next;
  logic [15:0] dout_reg, dout_next;
  logic        oe_reg, oe_next;
  udp_state_t  state_reg, state_next;

  udp_fifo_if fifo ();
  udp_ep_buffer #(.DEPTH(64)) u_buf (.clock(clock), .rst_b(rst_b), .fifo(fifo));

  logic [3:0] syncIn;
  udp_sync #(.WIDTH(4)) u_sync (
    .clock  (clock),
    .rst_b  (rst_b),
    .asyncIn({dmaAcknowledgeIn, transferEndIn, readStrobe_b, writeStrobe_b}),
    .syncOut(syncIn)
  );

  // ==================================================
  // decode helpers
  function automatic logic [3:0] idx_to_ep(input logic [3:0] idx);
    return 4'(idx - INDEX_FIRST);
  endfunction

  logic enable, ackOnly, burst, count_termination_enable, shortEn, wide, ackAct, eotAct, rdAct, wrAct;
  logic idxValid, dirIn, strobe, strobePrev_reg, strobeEdge, apbAcc, pioAcc, dmaStop, unitGo;
  logic [3:0] dmaEp;
  logic [4:0] burstLen;
  logic [1:0] unitBytes;

  always_comb begin
    enable   = cfg_reg[CFG_ENABLE_POS];
    ackOnly  = cfg_reg[CFG_ACKONLY_POS];
    burst    = cfg_reg[CFG_BURST_POS];
    count_termination_enable   = cfg_reg[CFG_COUNT_TERMINATION_ENABLE_POS];
    shortEn  = cfg_reg[CFG_SHORTP_POS];
    wide     = cfg_reg[CFG_WIDE_POS];
    // polarity bits flip the synchronised ack and end inputs, strobes stay active low
    ackAct   = syncIn[3] ^ ~cfg_reg[CFG_ACKPOL_POS];
    eotAct   = syncIn[2] ^ ~cfg_reg[CFG_EOTPOL_POS];
    rdAct    = ~syncIn[1];
    wrAct    = ~syncIn[0];
    // index 2..15 maps to endpoints 0..13
    idxValid = cfg_reg[CFG_INDEX_POS +: 4] >= INDEX_FIRST;
    // unmapped index parks on endpoint 0 so no lookup leaves the arrays
    dmaEp    = idxValid ? idx_to_ep(cfg_reg[CFG_INDEX_POS +: 4]) : 4'h0;
    // direction bit of the dma target
    dirIn    = endpoint_direction_bit_reg[dmaEp];
    // fly-by uses the strobe of the direction
    // ack-only ignores strobes, ack is the strobe
    strobe   = ackOnly ? ackAct : (ackAct && (dirIn ? wrAct : rdAct));
    unitBytes = wide ? 2'd2 : 2'd1;
    burstLen = burst ? 5'(BURST_BYTES / (wide ? 2 : 1)) : 5'd1;
    apbAcc   = psel && penable;
    // pio owns the buffer path only while it addresses the fifo window
    pioAcc   = !ackAct && psel && paddr == FIFO_OFFSET;
    // external end while a transfer is open
    dmaStop  = state_reg != UDP_IDLE && eotAct;
  end
  assign strobeEdge = strobe && !strobePrev_reg;
  // in ack-only mode ack and strobe rise together, so a unit may land while requesting
  assign unitGo = strobeEdge && (state_reg == UDP_REQ || state_reg == UDP_STROBE);

  // ==================================================
  // fifo path: dma wins while acknowledged, pio otherwise
  always_comb begin
    // acknowledge steers to the dma endpoint
    // pio keeps its own endpoint when idle
    fifo.epSel  = (pioAcc && !dmaStop) ? pioEp_reg : dmaEp;
    fifo.wide   = ackAct ? wide : 1'b0;
    fifo.wrData = ackAct ? dataIn : pwdata[15:0];
    fifo.rdStb  = 1'b0;
    fifo.wrStb  = 1'b0;
    fifo.flush  = 1'b0;
    if (unitGo) begin
      fifo.rdStb = !dirIn;
      fifo.wrStb = dirIn;
    end else if (pioAcc && penable && !dmaStop) begin
      fifo.rdStb = !pwrite;
      fifo.wrStb = pwrite;
    end
    // external end on an out endpoint drops the active buffer
    // a pio fifo access in that very cycle is lost, the end wins
    if (dmaStop && !dirIn) fifo.flush = 1'b1;
  end

  // ==================================================
  // dma state machine
  always_comb begin
    state_next  = state_reg;
    remain_next = remain_reg;
    burst_next  = burst_reg;
    stat_next   = stat_reg;
    dout_next   = dout_reg;
    oe_next     = oe_reg;
    cfg_next    = cfg_reg;
    stat_next[STAT_ACTIVE_POS] = state_reg != UDP_IDLE;
    case (state_reg)
      UDP_IDLE: begin
        burst_next = burstLen;
        if (enable && idxValid)
          state_next = UDP_REQ;
      end
      // unit budget is loaded before the request goes out, since the
      // first unit may arrive in the same cycle as the acknowledge
      UDP_REQ, UDP_STROBE: begin
        if (ackAct)
          state_next = UDP_STROBE;
        // present head data while read strobe is active
        if (!dirIn && strobe) begin
          dout_next = fifo.rdData;
          oe_next   = 1'b1;
        end
        if (unitGo) begin
          burst_next  = 5'(burst_reg - 5'd1);
          remain_next = 16'(remain_reg - 16'(unitBytes));
          // single drops after one unit, burst after last
          if (burst_reg <= 5'd1) state_next = UDP_WAIT;
        end
      end
      UDP_WAIT: begin
        burst_next = burstLen;
        if (!ackAct) state_next = UDP_REQ;
      end
      default: state_next = UDP_IDLE;
    endcase
    // release the bus once acknowledge is gone
    if (!ackAct) oe_next = 1'b0;
    if (state_reg != UDP_IDLE && eotAct) begin
      stat_next[STAT_EXTEND_POS] = 1'b1;
      stat_next[dirIn ? STAT_SEND_POS : STAT_DISCARD_POS] = 1'b1;
      cfg_next[CFG_ENABLE_POS] = 1'b0;
      state_next = UDP_IDLE;
    end
    if (count_termination_enable && state_reg != UDP_IDLE && remain_reg == 16'h0000) begin
      stat_next[STAT_CNTEND_POS] = 1'b1;
      cfg_next[CFG_ENABLE_POS] = 1'b0;
      state_next = UDP_IDLE;
    end
    // short packet ends dma on out endpoint once drained
    if (shortEn && shortPacket && !dirIn && state_reg != UDP_IDLE && fifo.level == 11'd0
        && !ackAct && !pioAcc) begin
      stat_next[STAT_SHORT_POS] = 1'b1;
      cfg_next[CFG_ENABLE_POS] = 1'b0;
      state_next = UDP_IDLE;
    end
    if (!enable) state_next = UDP_IDLE;
    // apb writes; set by hardware beats a write in the same cycle
    if (apbAcc && pwrite) begin
      case (paddr)
        CFG_OFFSET: begin
          cfg_next = pwdata;
          // loading the counter when dma gets enabled
          if (pwdata[CFG_ENABLE_POS] && !enable) remain_next = count_reg;
        end
        STATUS_OFFSET: stat_next = stat_next & ~pwdata[5:0] | (stat_next & ~stat_reg);
        default: ;
      endcase
    end
  end

  // ==================================================
  // apb write of plain registers
  always_comb begin
    count_next = count_reg;
    endpoint_direction_bit_next = endpoint_direction_bit_reg;
    pioEp_next = pioEp_reg;
    if (apbAcc && pwrite) begin
      if (paddr == COUNT_OFFSET) count_next = pwdata[15:0];
      if (paddr == ENDPOINT_DIRECTION_BIT_OFFSET) begin
        endpoint_direction_bit_next = pwdata[13:0];
        pioEp_next = pwdata[19:16];
      end
    end
  end

  // apb reads, zero wait states
  always_comb begin
    pready  = 1'b1;
    pslverr = 1'b0;
    prdata  = 32'h0000_0000;
    case (paddr)
      CFG_OFFSET:    prdata = cfg_reg;
      COUNT_OFFSET:  prdata = {remain_reg, count_reg};
      STATUS_OFFSET: prdata = {26'h0, stat_reg};
      ENDPOINT_DIRECTION_BIT_OFFSET:  prdata = {12'h0, pioEp_reg, 2'h0, endpoint_direction_bit_reg};
      FIFO_OFFSET:   prdata = {21'h0, fifo.level};
      default:       pslverr = psel && penable;
    endcase
  end

  // ==================================================
  // register bank
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cfg_reg        <= CFG_RESET;
      count_reg      <= COUNT_RESET;
      endpoint_direction_bit_reg      <= '0;
      pioEp_reg      <= '0;
      stat_reg       <= '0;
      remain_reg     <= COUNT_RESET;
      burst_reg      <= '0;
      dout_reg       <= '0;
      oe_reg         <= 1'b0;
      strobePrev_reg <= 1'b0;
      state_reg      <= UDP_IDLE;
    end else begin
      cfg_reg        <= cfg_next;
      count_reg      <= count_next;
      endpoint_direction_bit_reg      <= endpoint_direction_bit_next;
      pioEp_reg      <= pioEp_next;
      stat_reg       <= stat_next;
      remain_reg     <= remain_next;
      burst_reg      <= burst_next;
      dout_reg       <= dout_next;
      oe_reg         <= oe_next;
      strobePrev_reg <= strobe;
      state_reg      <= state_next;
    end
  end

  // request in REQ and STROBE states, polarity applied
  assign dmaRequestOut = (state_reg == UDP_REQ || state_reg == UDP_STROBE)
                         ^ ~cfg_reg[CFG_REQPOL_POS];
  assign dataOut  = dout_reg;
  assign dataOe_b = ~oe_reg;

  // ==================================================
  // checks
  // bus released after ack drops
  bus_release_a: assert property (@(posedge clock) disable iff (!rst_b)
    !ackAct |=> !oe_reg) else $error("data bus driven without acknowledge");
  single_drop_a: assert property (@(posedge clock) disable iff (!rst_b)
    (state_reg == UDP_STROBE && strobeEdge && burst_reg == 5'd1 && !eotAct && enable)
    |=> state_reg != UDP_STROBE) else $error("request held after last unit");
  count_end_a: assert property (@(posedge clock) disable iff (!rst_b)
    (count_termination_enable && state_reg != UDP_IDLE && remain_reg == 16'h0000 && !(apbAcc && pwrite))
    |=> !enable && stat_reg[STAT_CNTEND_POS]) else $error("count end missed");
  ext_end_a: assert property (@(posedge clock) disable iff (!rst_b)
    (state_reg != UDP_IDLE && eotAct && !(apbAcc && pwrite)) |=> state_reg == UDP_IDLE
    && stat_reg[STAT_EXTEND_POS]) else $error("external end missed");
  // ack steers fifo to dma endpoint
  ack_steer_a: assert property (@(posedge clock) disable iff (!rst_b)
    ackAct |-> fifo.epSel == dmaEp) else $error("ack not steering endpoint");
  ack_only_a: assert property (@(posedge clock) disable iff (!rst_b)
    ackOnly |-> strobe == ackAct) else $error("strobe used in ack-only mode");
  flyby_a: assert property (@(posedge clock) disable iff (!rst_b)
    (!ackOnly && !rdAct && !wrAct) |-> !strobe) else $error("fly-by strobe missing");
  // out endpoint never pushes from dma
  dir_out_a: assert property (@(posedge clock) disable iff (!rst_b)
    (ackAct && !dirIn) |-> !fifo.wrStb) else $error("write to out endpoint");
  // no request without a valid target index
  idx_guard_a: assert property (@(posedge clock) disable iff (!rst_b)
    (state_reg == UDP_IDLE && !idxValid) |=> state_reg == UDP_IDLE)
    else $error("dma started on unmapped index");
  // burst keeps requesting until its last unit
  burst_hold_a: assert property (@(posedge clock) disable iff (!rst_b)
    (unitGo && burst_reg > 5'd1) |=> state_reg != UDP_WAIT)
    else $error("burst request dropped early");
  // a fly-by read unit puts the head data on a driven bus
  sequence read_unit_s;
    unitGo && !dirIn && !ackOnly;
  endsequence
  sequence bus_driven_s;
    !dataOe_b && dataOut == $past(fifo.rdData);
  endsequence
  fly_read_a: assert property (@(posedge clock) disable iff (!rst_b)
    read_unit_s |=> bus_driven_s) else $error("read unit left bus idle");
  // drained short packet ends the transfer
  short_end_a: assert property (@(posedge clock) disable iff (!rst_b)
    (shortEn && shortPacket && !dirIn && state_reg != UDP_IDLE && fifo.level == 11'd0
     && !ackAct && !pioAcc && !(apbAcc && pwrite)) |=> state_reg == UDP_IDLE
    && stat_reg[STAT_SHORT_POS]) else $error("short packet end missed");
  // idle request sits at the inactive level of its polarity
  req_idle_a: assert property (@(posedge clock) disable iff (!rst_b)
    (state_reg == UDP_IDLE || state_reg == UDP_WAIT)
    |-> dmaRequestOut != cfg_reg[CFG_REQPOL_POS]) else $error("request active while idle");
  // external end on an out endpoint drops the dma buffer
  eot_flush_a: assert property (@(posedge clock) disable iff (!rst_b)
    (dmaStop && !dirIn) |-> fifo.flush && fifo.epSel == dmaEp)
    else $error("out buffer kept after external end");
endmodule

/* tb/udp_dma_ctl_model.sv */
// behavioural model of the external dma controller facing the port
`timescale 1ns/1ns
module udp_dma_ctl_model (
  input  wire logic        clock,            // system clock
  input  wire logic        dmaRequestOut,    // request from port
  input  wire logic [15:0] dataOut,          // port data out
  input  wire logic        dataOe_b,         // port drive enable, low
  input  wire logic        reqPol,           // request active level
  input  wire logic        ackPol,           // ack active level
  input  wire logic        ackOnly,          // ack doubles as strobe
  output logic             dmaAcknowledgeIn, // ack to port
  output logic             readStrobe_b,     // fly-by read strobe
  output logic             writeStrobe_b,    // fly-by write strobe
  output logic      [15:0] dataIn            // data bus toward port
);
  logic ackOn = 1'b0;
  // ==================================================
  // pin levels follow the programmed polarity
  assign dmaAcknowledgeIn = ackOn ? ackPol : ~ackPol;
  initial begin
    readStrobe_b = 1'b1;
    writeStrobe_b = 1'b1;
    dataIn = 16'hFFFF;
  end
  // ==================================================
  // one unit: wait request, ack, strobe, release
  task automatic unit(input logic rd, input logic [15:0] wd, output logic [15:0] rdat,
                      output logic reqMid, output logic oeMid, output logic oeEnd,
                      output logic ok);
    int n;
    n = 0;
    while (dmaRequestOut !== reqPol && n < 200) begin
      @(posedge clock);
      n++;
    end
    ok = (n < 200);
    @(posedge clock);
    if (!rd) dataIn <= wd;
    ackOn <= 1'b1;
    if (!ackOnly) begin
      @(posedge clock);
      readStrobe_b <= !rd;
      writeStrobe_b <= rd;
    end
    repeat (6) @(posedge clock);
    rdat = dataOut;
    reqMid = dmaRequestOut;
    oeMid = dataOe_b;
    readStrobe_b <= 1'b1;
    writeStrobe_b <= 1'b1;
    repeat (3) @(posedge clock);
    ackOn <= 1'b0;
    repeat (5) @(posedge clock);
    oeEnd = dataOe_b;
    // released bus must not look held, so it flips
    dataIn <= ~dataIn;
  endtask
endmodule

/* tb/tb_udp_dma_port.sv */
// self-checking testbench for the usb endpoint dma slave port
`timescale 1ns/1ns
module tb_udp_dma_port;
  import udp_pkg::*;
  logic        clock = 1'b0;
  logic        rst_b = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        dmaRequestOut;
  logic        dmaAcknowledgeIn;
  logic        transferEndIn = 1'b1;
  logic        readStrobe_b;
  logic        writeStrobe_b;
  logic [15:0] dataIn;
  logic [15:0] dataOut;
  logic        dataOe_b;
  logic        reqPol = 1'b0;
  logic        ackPol = 1'b0;
  logic        ackOnly = 1'b0;
  logic        shortPacket = 1'b0;
  int          err_total = 0;
  int          compares = 0;

  // ==================================================
  // design, far-side model, clock
  udp_dma_port i_udp_dma_port (.clock(clock), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dmaRequestOut(dmaRequestOut),
    .dmaAcknowledgeIn(dmaAcknowledgeIn), .transferEndIn(transferEndIn),
    .readStrobe_b(readStrobe_b), .writeStrobe_b(writeStrobe_b), .dataIn(dataIn),
    .dataOut(dataOut), .dataOe_b(dataOe_b), .shortPacket(shortPacket));
  udp_dma_ctl_model i_udp_dma_ctl_model (.clock(clock), .dmaRequestOut(dmaRequestOut),
    .dataOut(dataOut), .dataOe_b(dataOe_b), .reqPol(reqPol), .ackPol(ackPol),
    .ackOnly(ackOnly), .dmaAcknowledgeIn(dmaAcknowledgeIn), .readStrobe_b(readStrobe_b),
    .writeStrobe_b(writeStrobe_b), .dataIn(dataIn));
  always #20 clock = ~clock;

  // ==================================================
  // verdict, compare, bus tasks
  task automatic end_sim;
    if (err_total == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // idle cycle first, so psel never changes twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 16);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      err_total++;
      end_sim();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask
  task automatic xfer(input logic r, input logic [15:0] wd, output logic [15:0] d,
                      output logic q, output logic o, output logic f);
    logic ok;
    i_udp_dma_ctl_model.unit(r, wd, d, q, o, f, ok);
    if (!ok) begin
      err_total++;
      end_sim();
    end
  endtask

  // ==================================================
  // scenarios
  task automatic test_reset;
    logic [31:0] r;
    logic        e;
    chk(dmaRequestOut, 1'b1);
    chk(dataOe_b, 1'b1);
    rd(CFG_OFFSET, r); chk(r, CFG_RESET);
    rd(COUNT_OFFSET, r); chk(r, 32'h0);
    rd(STATUS_OFFSET, r); chk(r, 32'h0);
    apb(1'b0, 8'h14, 32'h0, r, e); chk(e, 1'b1);
  endtask
  // out endpoint 2 read by fly-by while pio works on endpoint 4
  task automatic test_flyby_out;
    logic [31:0] r;
    logic [15:0] d;
    logic        q, o, f;
    wr(ENDPOINT_DIRECTION_BIT_OFFSET, 32'h0002_0000);
    for (int i = 0; i < 4; i++) wr(FIFO_OFFSET, 32'hA0 + i);
    wr(ENDPOINT_DIRECTION_BIT_OFFSET, 32'h0004_0000);
    wr(CFG_OFFSET, 32'h0000_0401);
    for (int i = 0; i < 2; i++) begin
      xfer(1'b1, 16'h0, d, q, o, f);
      chk(d[7:0], 32'hA0 + i);
      chk(o, 1'b0);
      chk(q, 1'b1);
      chk(f, 1'b1);
      wr(FIFO_OFFSET, 32'h55);
    end
    transferEndIn <= 1'b0;
    repeat (4) @(posedge clock);
    transferEndIn <= 1'b1;
    repeat (4) @(posedge clock);
    rd(STATUS_OFFSET, r); chk(r[5:0], 6'b100010);
    rd(CFG_OFFSET, r); chk(r[0], 1'b0);
    rd(FIFO_OFFSET, r); chk(r[10:0], 11'd2);
    wr(ENDPOINT_DIRECTION_BIT_OFFSET, 32'h0002_0000);
    rd(FIFO_OFFSET, r); chk(r[10:0], 11'd0);
    wr(STATUS_OFFSET, 32'h3F);
  endtask
  // in endpoint 2 written in ack-only burst, ended by the count
  task automatic test_ackonly_in;
    logic [31:0] r;
    logic [15:0] d;
    logic        q, o, f;
    wr(ENDPOINT_DIRECTION_BIT_OFFSET, 32'h0002_0004);
    wr(COUNT_OFFSET, 32'h4);
    wr(CFG_OFFSET, 32'h0000_046E);
    @(posedge clock);
    chk(dmaRequestOut, 1'b0);
    reqPol <= 1'b1;
    ackPol <= 1'b1;
    ackOnly <= 1'b1;
    wr(CFG_OFFSET, 32'h0000_046F);
    for (int i = 0; i < 4; i++) begin
      xfer(1'b0, 16'h0030 + 16'(i), d, q, o, f);
      if (i < 3) chk(q, 1'b1);
      chk(o, 1'b1);
    end
    repeat (4) @(posedge clock);
    rd(STATUS_OFFSET, r); chk(r[2], 1'b1);
    rd(COUNT_OFFSET, r); chk(r, 32'h0000_0004);
    rd(CFG_OFFSET, r); chk(r[0], 1'b0);
    chk(dmaRequestOut, 1'b0);
    rd(FIFO_OFFSET, r); chk(r[10:0], 11'd4);
    wr(STATUS_OFFSET, 32'h3F);
  endtask
  // out endpoint 3 read in ack-only mode, ended by a short packet
  task automatic test_short_out;
    logic [31:0] r;
    logic [15:0] d;
    logic        q, o, f;
    wr(ENDPOINT_DIRECTION_BIT_OFFSET, 32'h0003_0000);
    wr(FIFO_OFFSET, 32'h77);
    shortPacket <= 1'b1;
    wr(CFG_OFFSET, 32'h0000_0573);
    xfer(1'b1, 16'h0, d, q, o, f);
    chk(d[7:0], 32'h77);
    chk(q, 1'b0);
    chk(o, 1'b0);
    chk(f, 1'b1);
    rd(STATUS_OFFSET, r); chk(r[3], 1'b1);
    rd(CFG_OFFSET, r); chk(r[0], 1'b0);
    shortPacket <= 1'b0;
    wr(STATUS_OFFSET, 32'h3F);
  endtask

  // ==================================================
  // main sequence: reset for 8 cycles, then scenarios
  initial begin
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    test_reset();
    test_flyby_out();
    test_ackonly_in();
    test_short_out();
    end_sim();
  end
endmodule
